//--- inc/clk_sel_pkg.sv
// Package of register map, field layout and types for the system clock select block
// Functional notes
// - Slow type bit changes only in fast mode
// - Slow type 0 slow RC, 1 crystal
// - Halt bit 1 stops fast sub-oscillator
// - Halt bit changes in slow/alternate mode only
// - Clock choice writable if sub running/alternate
// - Choice 0 runs system from slow source
// - Divider field 000..101 divides 32..1, reset 101
// - Five-bit trim tunes fast RC frequency
// - Alternate halt bit stops alternate RC
// - Fast kind 0 sub source, 1 alternate
// - Choice 1 runs system from fast source
package clk_sel_pkg;
  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] CLOCK_CONTROL_OFS     = 8'hD8;
  localparam logic [7:0] RC_TRIM_CONFIG_OFS    = 8'hF7;
  localparam logic [7:0] AUXILIARY_CONTROL_OFS = 8'hF8;
  localparam logic [7:0] FAST_SUB_SELECT_OFS   = 8'hF9;
  localparam logic [7:0] CLOCK_STATUS_OFS      = 8'hFA;
  // ****************************************
  // Field positions
  // ****************************************
  localparam int FAST_KIND_BIT    = 7;
  localparam int SYS_CHOICE_BIT   = 5;
  localparam int SLOW_TYPE_BIT    = 4;
  localparam int SUB_HALT_BIT     = 3;
  localparam int DIV_LSB          = 0;
  localparam int DIV_W            = 3;
  localparam int TRIM_W           = 5;
  localparam int ALT_HALT_BIT     = 1;
  localparam int SUB_CRYSTAL_BIT  = 0;
  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [2:0] DIV_RESET  = 3'h5;
  localparam logic [4:0] TRIM_RESET = 5'h00;
  localparam logic [2:0] DIV_BY_ONE = 3'h5;
  // Selected oscillator source
  typedef enum logic [2:0] {
    SRC_SLOW_RC,
    SRC_SLOW_XTAL,
    SRC_FAST_RC,
    SRC_FAST_XTAL,
    SRC_ALT_RC
  } clk_src_e;
  // Oscillator enables and pin ownership
  typedef struct packed {
    logic slowRcOn;
    logic slowXtalOn;
    logic fastRcOn;
    logic fastXtalOn;
    logic altRcOn;
    logic slowXtalPins;
    logic fastXtalPins;
  } osc_ctl_s;
endpackage

//--- verilog/system_clock_select.sv
// System clock source select, prescaler and oscillator control with Wishbone slave
`timescale 1ns/1ps
module system_clock_select (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 resetn,
  // Wishbone classic slave
  input  wire logic                 cycI,
  input  wire logic                 stbI,
  input  wire logic                 weI,
  input  wire logic [7:0]           adrI,
  input  wire logic [3:0]           selI,
  input  wire logic [31:0]          datI,
  output logic      [31:0]          datO,
  output logic                      ackO,
  output logic                      errO,
  // Oscillator control
  output clk_sel_pkg::osc_ctl_s     oscCtl,
  output clk_sel_pkg::clk_src_e     clkSource,
  output logic      [4:0]           fastRcTrim,
  // Divided clock enable pulse
  output logic                      sysClkEn
);
  import clk_sel_pkg::*;

  // ****************************************
  // Control registers
  // ****************************************
  logic             fastSourceKind;
  logic             systemClockChoice;
  logic             slowSourceType;
  logic             fastSubOscHalt;
  logic [DIV_W-1:0] clockDividerField;
  logic [TRIM_W-1:0] trimReg;
  logic             alternateRcHalt;
  logic             fastSubCrystal;
  logic [4:0]       divCount;

  // ****************************************
  // Bus decode
  // ****************************************
  wire       access     = cycI & stbI & ~ackO & ~errO;
  wire       hitCtl     = adrI == CLOCK_CONTROL_OFS;
  wire       hitTrim    = adrI == RC_TRIM_CONFIG_OFS;
  wire       hitAux     = adrI == AUXILIARY_CONTROL_OFS;
  wire       hitSub     = adrI == FAST_SUB_SELECT_OFS;
  wire       hitStat    = adrI == CLOCK_STATUS_OFS;
  wire       mapped     = hitCtl | hitTrim | hitAux | hitSub | hitStat;
  wire       wrLane0    = access & weI & selI[0];
  wire       wrCtl      = wrLane0 & hitCtl;
  wire       wrTrim     = wrLane0 & hitTrim;
  wire       wrAux      = wrLane0 & hitAux;
  wire       wrSub      = wrLane0 & hitSub;
  wire [7:0] wd         = datI[7:0];

  // ****************************************
  // Mode permission terms
  // ****************************************
  wire fastMode       = systemClockChoice;
  wire slowMode       = ~systemClockChoice;
  wire mayTypeSlow    = fastMode;
  wire mayHaltSub     = slowMode | fastSourceKind;
  wire mayChoose      = ~fastSubOscHalt | fastSourceKind;
  wire mayKindFast    = slowMode;

  // Next values; disallowed writes keep the old bit
  wire next_slowSourceType    = (wrCtl & mayTypeSlow) ? wd[SLOW_TYPE_BIT] : slowSourceType;
  wire next_fastSubOscHalt    = (wrCtl & mayHaltSub) ? wd[SUB_HALT_BIT] : fastSubOscHalt;
  wire next_systemClockChoice = (wrCtl & mayChoose) ? wd[SYS_CHOICE_BIT] : systemClockChoice;
  wire next_fastSourceKind    = (wrAux & mayKindFast) ? wd[FAST_KIND_BIT] : fastSourceKind;
  wire next_fastSubCrystal    = (wrSub & slowMode) ? wd[SUB_CRYSTAL_BIT] : fastSubCrystal;

  // Control register update
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      slowSourceType    <= 1'b0;
      fastSubOscHalt    <= 1'b0;
      systemClockChoice <= 1'b0;
      fastSourceKind    <= 1'b0;
      fastSubCrystal    <= 1'b0;
    end else begin
      slowSourceType    <= next_slowSourceType;
      fastSubOscHalt    <= next_fastSubOscHalt;
      systemClockChoice <= next_systemClockChoice;
      fastSourceKind    <= next_fastSourceKind;
      fastSubCrystal    <= next_fastSubCrystal;
    end
  end

  // Unrestricted fields
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      clockDividerField <= DIV_RESET;
      trimReg           <= TRIM_RESET;
      alternateRcHalt   <= 1'b0;
    end else begin
      if (wrCtl) begin
        clockDividerField <= wd[DIV_LSB +: DIV_W];
      end
      if (wrTrim) begin
        trimReg <= wd[TRIM_W-1:0];
      end
      if (wrAux) begin
        alternateRcHalt <= wd[ALT_HALT_BIT];
      end
    end
  end

  // ****************************************
  // Source selection and oscillator enables
  // ****************************************
  wire [2:0] next_src =
      !systemClockChoice ? (slowSourceType ? SRC_SLOW_XTAL : SRC_SLOW_RC) :
      fastSourceKind     ? SRC_ALT_RC :
      fastSubCrystal     ? SRC_FAST_XTAL : SRC_FAST_RC;
  wire osc_ctl_s next_osc = '{
      slowRcOn:     ~slowSourceType,
      slowXtalOn:   slowSourceType,
      fastRcOn:     ~fastSubOscHalt & ~fastSubCrystal,
      fastXtalOn:   ~fastSubOscHalt & fastSubCrystal,
      altRcOn:      ~alternateRcHalt,
      slowXtalPins: slowSourceType,
      fastXtalPins: fastSubCrystal};

  // ****************************************
  // Prescaler: divide by 2^(5-field), by 1 for fields 5 to 7
  // ****************************************
  function automatic logic [4:0] div_mask(input logic [2:0] f);
    logic [4:0] m;
    m = 5'h00;
    case (f)
      3'h0:    m = 5'h1F;
      3'h1:    m = 5'h0F;
      3'h2:    m = 5'h07;
      3'h3:    m = 5'h03;
      3'h4:    m = 5'h01;
      default: m = 5'h00;
    endcase
    return m;
  endfunction

  wire [4:0] mask     = div_mask(clockDividerField);
  wire       divWrap  = (divCount & mask) == mask;
  wire [4:0] next_div = divWrap ? 5'h00 : 5'(divCount + 5'h01);

  // Prescaler counter and enable pulse
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      divCount <= 5'h00;
      sysClkEn <= 1'b0;
    end else begin
      divCount <= next_div;
      sysClkEn <= divWrap;
    end
  end

  // ****************************************
  // Read data and answer
  // ****************************************
  wire [7:0] rdCtl  = {2'b00, systemClockChoice, slowSourceType, fastSubOscHalt, clockDividerField};
  wire [7:0] rdAux  = {fastSourceKind, 5'b00000, alternateRcHalt, 1'b0};
  wire [7:0] rdStat = {5'b00000, next_src};
  wire [7:0] rdByte = hitCtl  ? rdCtl :
                      hitTrim ? {3'b000, trimReg} :
                      hitAux  ? rdAux :
                      hitSub  ? {7'b0000000, fastSubCrystal} :
                      hitStat ? rdStat : 8'h00;

  // Single-cycle ack or err, dropped the cycle after
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ackO <= 1'b0;
      errO <= 1'b0;
      datO <= 32'h00000000;
    end else begin
      ackO <= access & mapped;
      errO <= access & ~mapped;
      datO <= (access & ~weI) ? {24'h000000, rdByte} : 32'h00000000;
    end
  end

  // Registered clock outputs
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      clkSource  <= SRC_SLOW_RC;
      oscCtl     <= '{slowRcOn: 1'b1, altRcOn: 1'b1, fastRcOn: 1'b1, default: 1'b0};
      fastRcTrim <= TRIM_RESET;
    end else begin
      clkSource  <= clk_src_e'(next_src);
      oscCtl     <= next_osc;
      fastRcTrim <= trimReg;
    end
  end
endmodule

//--- dv/system_clock_select_checker.sv
// Port-level assertions for the clock select block
`timescale 1ns/1ps
module system_clock_select_checker
  import clk_sel_pkg::*;
(
  // Clock, reset and bus
  input wire logic                  clk, resetn, cycI, stbI, weI, ackO, errO, sysClkEn,
  input wire logic [7:0]            adrI,
  input wire logic [3:0]            selI,
  input wire logic [31:0]           datI, datO,
  // Oscillator outputs
  input wire clk_sel_pkg::osc_ctl_s oscCtl,
  input wire clk_sel_pkg::clk_src_e clkSource,
  input wire logic [4:0]            fastRcTrim
);
  // Accepted byte write and mode decode
  wire wrOk    = cycI && stbI && weI && selI[0] && !ackO && !errO;
  wire slowNow = clkSource inside {SRC_SLOW_RC, SRC_SLOW_XTAL};
  wire subNow  = clkSource inside {SRC_FAST_RC, SRC_FAST_XTAL};
  wire fastOn  = oscCtl.fastRcOn || oscCtl.fastXtalOn;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence s_ctl; wrOk && adrI == CLOCK_CONTROL_OFS; endsequence
  sequence s_aux; wrOk && adrI == AUXILIARY_CONTROL_OFS; endsequence
  a_trim_follows: assert property (wrOk && adrI == RC_TRIM_CONFIG_OFS
    |-> ##2 fastRcTrim == $past(datI[4:0], 2)) else $error("trim output not loaded");
  a_slow_select: assert property (s_ctl ##0 (!datI[5] && fastOn) |-> ##3 slowNow)
    else $error("slow source not selected");
  a_fast_select: assert property (s_ctl ##0 (datI[5] && fastOn) |-> ##3 !slowNow)
    else $error("fast source not selected");
  a_type_locked: assert property (s_ctl ##0 (!datI[5] && slowNow)
    |-> ##3 clkSource == $past(clkSource, 3)) else $error("slow type changed in slow mode");
  a_xtal_pins: assert property (clkSource == SRC_SLOW_XTAL |-> oscCtl.slowXtalPins && oscCtl.slowXtalOn)
    else $error("crystal pins not taken");
  a_sub_running: assert property (subNow |-> fastOn) else $error("fast source halted");
  a_halt_locked: assert property (s_ctl ##0 (datI[5] && datI[3] && subNow) |-> ##3 fastOn)
    else $error("halt accepted in fast mode");
  a_halt_stops: assert property (s_ctl ##0 (!datI[5] && datI[3] && slowNow) |-> ##3 !fastOn)
    else $error("fast oscillator still on");
  a_alt_halt: assert property (s_aux |-> ##3 oscCtl.altRcOn == !$past(datI[1], 3))
    else $error("alternate oscillator state wrong");
endmodule
bind system_clock_select system_clock_select_checker system_clock_select_checker_inst (.*);

//--- dv/system_clock_select_bench.sv
// Self-checking bench for the clock select block
`timescale 1ns/1ps
module system_clock_select_bench;
  import clk_sel_pkg::*;
  logic        clk = 0, resetn = 0, cycI = 0, stbI = 0, weI = 0, ackO, errO, sysClkEn, er;
  logic [7:0]  adrI = 8'h00, q;
  logic [3:0]  selI = 4'h0;
  logic [31:0] datI = 32'h0, datO;
  osc_ctl_s    oscCtl;
  clk_src_e    clkSource;
  logic [4:0]  fastRcTrim;
  int          errors = 0, checks_done = 0;
  always #25 clk = ~clk;
  system_clock_select system_clock_select_inst (.*);
  // Compare and count
  task automatic chk(input string nm, input logic [31:0] s, e);
    checks_done++;
    if (s !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  // One classic bus cycle
  task automatic wb(input logic w, input logic [7:0] a, d);
    int n;
    @(posedge clk);
    {cycI, stbI, weI, selI, adrI, datI} <= {2'b11, w, 4'hF, a, 24'h0, d};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ackO !== 1'b1 && errO !== 1'b1 && n < 50);
    if (n >= 50) begin
      errors++;
      $display("MISMATCH bus answer expected ack seen none");
    end
    q = datO[7:0];
    er = errO;
    {cycI, stbI} <= 2'b00;
  endtask
  // Write then read back
  task automatic wc(input logic [7:0] a, d, e);
    wb(1'b1, a, d);
    wb(1'b0, a, 8'h00);
    chk("readback", q, e);
  endtask
  task automatic t_reset();
    wb(1'b0, CLOCK_CONTROL_OFS, 8'h00);
    chk("ctl", q, 8'h05);
    wb(1'b0, AUXILIARY_CONTROL_OFS, 8'h00);
    chk("aux", q, 8'h00);
    chk("src", clkSource, SRC_SLOW_RC);
    wb(1'b0, 8'h10, 8'h00);
    chk("unmapped", er, 1'b1);
  endtask
  task automatic t_trim();
    logic [7:0] v[3] = '{8'h00, 8'h0F, 8'h10};
    foreach (v[i]) begin
      wc(RC_TRIM_CONFIG_OFS, v[i], v[i]);
      chk("trim", fastRcTrim, v[i][4:0]);
    end
  endtask
  task automatic t_modes();
    wc(CLOCK_CONTROL_OFS, 8'h15, 8'h05);
    wc(CLOCK_CONTROL_OFS, 8'h0D, 8'h0D);
    chk("fastOff", oscCtl.fastRcOn | oscCtl.fastXtalOn, 1'b0);
    wc(CLOCK_CONTROL_OFS, 8'h2D, 8'h0D);
    wc(CLOCK_CONTROL_OFS, 8'h05, 8'h05);
    wc(CLOCK_CONTROL_OFS, 8'h25, 8'h25);
    chk("src", clkSource, SRC_FAST_RC);
    wc(CLOCK_CONTROL_OFS, 8'h35, 8'h35);
    wc(CLOCK_CONTROL_OFS, 8'h3D, 8'h35);
    wc(CLOCK_CONTROL_OFS, 8'h15, 8'h15);
    chk("src", clkSource, SRC_SLOW_XTAL);
    chk("pins", oscCtl.slowXtalPins, 1'b1);
    wc(FAST_SUB_SELECT_OFS, 8'h01, 8'h01);
    chk("fxtalOn", oscCtl.fastXtalOn, 1'b1);
    chk("fxtalPins", oscCtl.fastXtalPins, 1'b1);
    wc(CLOCK_CONTROL_OFS, 8'h35, 8'h35);
    chk("src", clkSource, SRC_FAST_XTAL);
    wc(FAST_SUB_SELECT_OFS, 8'h00, 8'h01);
    wc(CLOCK_CONTROL_OFS, 8'h15, 8'h15);
    wc(FAST_SUB_SELECT_OFS, 8'h00, 8'h00);
    chk("src", clkSource, SRC_SLOW_XTAL);
  endtask
  task automatic t_kind();
    wc(AUXILIARY_CONTROL_OFS, 8'h80, 8'h80);
    wc(CLOCK_CONTROL_OFS, 8'h25, 8'h35);
    chk("src", clkSource, SRC_ALT_RC);
    wb(1'b0, CLOCK_STATUS_OFS, 8'h00);
    chk("status", q, 8'h04);
    wc(AUXILIARY_CONTROL_OFS, 8'h02, 8'h82);
    chk("altOff", oscCtl.altRcOn, 1'b0);
    wc(AUXILIARY_CONTROL_OFS, 8'h80, 8'h80);
    wc(CLOCK_CONTROL_OFS, 8'h2D, 8'h2D);
  endtask
  // Pulse spacing for divider codes 0 to 5
  task automatic t_div();
    int n;
    for (int k = 0; k < 6; k++) begin
      wc(CLOCK_CONTROL_OFS, 8'h28 | k[7:0], 8'h28 | k[7:0]);
      repeat (70) @(posedge clk);
      n = 0;
      while (sysClkEn !== 1'b1 && n < 100) begin
        @(posedge clk);
        n++;
      end
      n = 0;
      do begin
        @(posedge clk);
        n++;
      end while (sysClkEn !== 1'b1 && n < 100);
      chk("gap", n, 32 >> k);
    end
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    t_reset();
    t_trim();
    t_modes();
    t_kind();
    t_div();
    close_out();
  end
  // Watchdog
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    close_out();
  end
endmodule
